// >>> rtl/ids_sequencer.v
// Interrupt dispatch sequencer with Wishbone register access
// Operation
// RULE1: Pending conditions live in two flag registers, polled while idle.
// RULE2: Test order: interrupt stack, misc, trap, module, parity, panel.
// RULE3: No tests for absence, trace or uncallable entry conditions.
// RULE4: Power-on with restart disabled enters the halt loop directly.
// RULE5: Power-on restart: Q=QI, Z=ZI, S=word at QI-5, clear DB, DL.
// RULE6: Other stack-type interrupts push a four-word marker then DB.
// RULE7: Off interrupt stack: save S at QI-5, switch Q, Z, S.
// RULE8: On stack in dispatcher: reload Q, Z, S=QI+1; else keep them.
// RULE9: Misc errors push only a four-word marker before transfer.
// RULE10: Arithmetic trap with traps disabled sets overflow, nothing more.
// RULE11: System traps and enabled arithmetic traps push marker, transfer.
// RULE12: Module error inside its segment halts; else marker and transfer.
// RULE13: Parity error inside its segment halts; else marker and transfer.
// RULE14: Push the interrupt parameter only when the type needs one.
// RULE15: External enable cleared during setup; stays clear for internal.
// RULE16: External: code base 0, limit all ones, P and DB from entry.
// RULE17: External: status mode privileged, external enable set again.
// RULE18: Internal: base, limit from table, P = base, set reference bit.
// RULE19: Internal: status mode from entry, segment number in bits 8-15.
// RULE20: Finally fetch the instruction at P and start the routine.
// RULE21: Entry address is word 0 plus twice segment; base word second.
// RULE22: Entry mode flag in bit 1, status mode flag in bit 0.
// RULE23: The serviced pending flag clears when its dispatch begins.
`timescale 1ns/1ps
`default_nettype none
`include "ids_defines.vh"

module ids_sequencer (
  input  wire        CLK_IN,          // 125 MHz clock
  input  wire        RESETN_IN,       // Async reset, active low
  input  wire        WB_CYC_IN,       // Wishbone cycle
  input  wire        WB_STB_IN,       // Wishbone strobe
  input  wire        WB_WE_IN,        // Wishbone write enable
  input  wire [7:0]  WB_ADR_IN,       // Wishbone byte address
  input  wire [3:0]  WB_SEL_IN,       // Wishbone byte selects
  input  wire [31:0] WB_DAT_IN,       // Wishbone write data
  output reg  [31:0] WB_DAT_OUT,      // Wishbone read data
  output reg         WB_ACK_OUT,      // Wishbone acknowledge
  input  wire [15:0] FLAG1_SET_IN,    // Set pulses, flags one
  input  wire [15:0] FLAG2_SET_IN,    // Set pulses, flags two
  output reg         MEM_REQ_OUT,     // Memory request
  output reg         MEM_WE_OUT,      // Memory write
  output reg  [15:0] MEM_ADDR_OUT,    // Memory word address
  output reg  [15:0] MEM_WDATA_OUT,   // Memory write data
  input  wire [15:0] MEM_RDATA_IN,    // Memory read data
  input  wire        MEM_ACK_IN,      // Memory acknowledge pulse
  output reg         HALT_LAMP_OUT,   // System halt indicator
  output reg         BUSY_OUT,        // Dispatch in progress
  output reg         EXEC_START_OUT   // Routine starts, one pulse
);

  // ****************************************************************
  // States and kinds
  // ****************************************************************
  localparam [3:0] ST_IDLE = 4'h0, ST_MARK = 4'h1, ST_PUSHDB = 4'h2,
                   ST_RDQI = 4'h3, ST_RDZI = 4'h4, ST_RDS = 4'h5,
                   ST_SAVES = 4'h6, ST_PARM = 4'h7, ST_RDTP = 4'h8,
                   ST_ENT0 = 4'h9, ST_ENT1 = 4'hA, ST_WREF = 4'hB,
                   ST_DRT0 = 4'hC, ST_DRT1 = 4'hD, ST_FETCH = 4'hE;
  localparam [3:0] K_NONE = 4'h0, K_POWER = 4'h1, K_ICS = 4'h2,
                   K_EXT = 4'h3, K_PUSH = 4'h4, K_OVF = 4'h5,
                   K_STOP = 4'h6, K_PANEL = 4'h7;

  reg  [3:0]  state;
  reg  [15:0] flags1;
  reg  [15:0] flags2;
  reg  [4:0]  ctrl;
  reg  [15:0] stat;
  reg  [15:0] q, z, s, db, dl, pb, pl, p, x, parm, instr;
  reg  [7:0]  dev;
  reg  [15:0] qi, zi, tp, ent0;
  reg  [1:0]  idx;
  reg         pw, interrupt_control_stack, ext, need_parm;
  reg  [7:0]  seg;
  reg  [3:0]  kind;
  reg  [15:0] clr1, clr2;
  reg  [7:0]  kseg;
  reg         kparm;
  reg  [31:0] rd;

  wire        wb_hit  = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  wire        wb_wr   = wb_hit & WB_WE_IN;
  wire        ack_now = MEM_REQ_OUT & MEM_ACK_IN;
  wire [15:0] ent_adr = tp + {seg[6:0], 1'b0};
  wire [15:0] drt_adr = {6'h00, dev, 2'h0};
  wire        halt    = ctrl[`IDS_C_HALT];

  function [15:0] f_merge;
    input [15:0] old;
    input [15:0] dat;
    input [1:0]  sel;
    begin
      f_merge = {sel[1] ? dat[15:8] : old[15:8],
                 sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction
  wire [15:0] ctrl_w  = f_merge({11'h000, ctrl}, WB_DAT_IN[15:0],
                                WB_SEL_IN[1:0]);

  task t_mem;
    input        we;
    input [15:0] adr;
    input [15:0] dat;
    begin
      MEM_REQ_OUT   <= 1'b1;
      MEM_WE_OUT    <= we;
      MEM_ADDR_OUT  <= adr;
      MEM_WDATA_OUT <= dat;
    end
  endtask

  // ****************************************************************
  // Classification of the pending condition
  // ****************************************************************
  always @* begin
    kind  = K_NONE;
    clr1  = 16'h0000;
    clr2  = 16'h0000;
    kseg  = 8'h00;
    kparm = 1'b0;
    if (state == ST_IDLE) begin
      if (!halt && ctrl[`IDS_C_RUN]) begin              // [RULE2] [RULE3]
        if (flags1[`IDS_F1_POWER]) begin
          kind = K_POWER;
          kseg = `IDS_SEG_POWER;
          clr1[`IDS_F1_POWER] = 1'b1;
        end else if (flags1[`IDS_F1_ICSI]) begin
          kind  = K_ICS;
          kseg  = `IDS_SEG_ICSI;
          kparm = 1'b1;
          clr1[`IDS_F1_ICSI] = 1'b1;
        end else if (flags1[`IDS_F1_EXT] && stat[`IDS_ST_EXTEN]) begin
          kind = K_EXT;
          clr1[`IDS_F1_EXT] = 1'b1;
        end else if (flags1[`IDS_F1_MISC]) begin
          kind = K_PUSH;                                 // [RULE9]
          kseg = `IDS_SEG_MISC;
          clr1[`IDS_F1_MISC] = 1'b1;
        end else if (flags2[`IDS_F2_SYS]) begin
          kind  = K_PUSH;                                // [RULE11]
          kseg  = `IDS_SEG_TRAP;
          kparm = 1'b1;
          clr2[`IDS_F2_SYS] = 1'b1;
        end else if (flags2[`IDS_F2_ARITH]) begin
          kind  = stat[`IDS_ST_TRAPEN] ? K_PUSH : K_OVF; // [RULE10]
          kseg  = `IDS_SEG_TRAP;
          kparm = 1'b1;
          clr2[`IDS_F2_ARITH] = 1'b1;
        end else if (flags1[`IDS_F1_MOD]) begin
          kind  = (stat[15:8] == `IDS_SEG_MOD) ? K_STOP : K_PUSH;
          kseg  = `IDS_SEG_MOD;
          kparm = 1'b1;
          clr1[`IDS_F1_MOD] = 1'b1;                       // [RULE12]
        end else if (flags1[`IDS_F1_PAR]) begin
          kind = (stat[15:8] == `IDS_SEG_PAR) ? K_STOP : K_PUSH;
          kseg = `IDS_SEG_PAR;
          clr1[`IDS_F1_PAR] = 1'b1;                       // [RULE13]
        end
      end
      if (kind == K_NONE && flags1[`IDS_F1_PANEL]) begin
        kind = K_PANEL;
        clr1[`IDS_F1_PANEL] = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  always @* begin
    rd = 32'h0000_0000;
    case (WB_ADR_IN)
      `IDS_A_FLAGS1: rd[15:0] = flags1;
      `IDS_A_FLAGS2: rd[15:0] = flags2;
      `IDS_A_CTRL:   rd[4:0]  = ctrl;
      `IDS_A_STAT:   rd[15:0] = stat;
      `IDS_A_Q:      rd[15:0] = q;
      `IDS_A_Z:      rd[15:0] = z;
      `IDS_A_S:      rd[15:0] = s;
      `IDS_A_DB:     rd[15:0] = db;
      `IDS_A_DL:     rd[15:0] = dl;
      `IDS_A_PB:     rd[15:0] = pb;
      `IDS_A_PL:     rd[15:0] = pl;
      `IDS_A_P:      rd[15:0] = p;
      `IDS_A_X:      rd[15:0] = x;
      `IDS_A_PARM:   rd[15:0] = parm;
      `IDS_A_DEV:    rd[7:0]  = dev;
      `IDS_A_STATE:  rd[4:0]  = {BUSY_OUT, state};
      `IDS_A_INSTR:  rd[15:0] = instr;
      default:       rd = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Bus slave, flags and dispatch sequencer
  // ****************************************************************
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      WB_ACK_OUT     <= 1'b0;
      WB_DAT_OUT     <= 32'h0000_0000;
      MEM_REQ_OUT    <= 1'b0;
      MEM_WE_OUT     <= 1'b0;
      MEM_ADDR_OUT   <= 16'h0000;
      MEM_WDATA_OUT  <= 16'h0000;
      HALT_LAMP_OUT  <= 1'b0;
      BUSY_OUT       <= 1'b0;
      EXEC_START_OUT <= 1'b0;
      state <= ST_IDLE;
      flags1 <= 16'h0000;
      flags2 <= 16'h0000;
      ctrl <= `IDS_R_CTRL;
      stat <= `IDS_R_STAT;
      q <= 16'h0000;  z <= 16'h0000;  s <= 16'h0000;
      db <= 16'h0000; dl <= 16'h0000; pb <= 16'h0000;
      pl <= 16'h0000; p <= 16'h0000;  x <= 16'h0000;
      parm <= 16'h0000; instr <= 16'h0000; dev <= 8'h00;
      qi <= 16'h0000; zi <= 16'h0000; tp <= 16'h0000;
      ent0 <= 16'h0000; idx <= 2'h0; seg <= 8'h00;
      pw <= 1'b0; interrupt_control_stack <= 1'b0; ext <= 1'b0; need_parm <= 1'b0;
    end else begin
      WB_ACK_OUT     <= wb_hit;
      WB_DAT_OUT     <= rd;
      EXEC_START_OUT <= 1'b0;
      HALT_LAMP_OUT  <= halt;
      BUSY_OUT       <= (state != ST_IDLE);
      if (wb_wr) begin
        case (WB_ADR_IN)
          `IDS_A_CTRL:  ctrl <= ctrl_w[4:0];
          `IDS_A_STAT:  stat <= f_merge(stat, WB_DAT_IN[15:0],
                                        WB_SEL_IN[1:0]);
          `IDS_A_Q:     q <= f_merge(q, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_Z:     z <= f_merge(z, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_S:     s <= f_merge(s, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_DB:    db <= f_merge(db, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_DL:    dl <= f_merge(dl, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_PB:    pb <= f_merge(pb, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_PL:    pl <= f_merge(pl, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_P:     p <= f_merge(p, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_X:     x <= f_merge(x, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
          `IDS_A_PARM:  parm <= f_merge(parm, WB_DAT_IN[15:0],
                                        WB_SEL_IN[1:0]);
          `IDS_A_DEV:   if (WB_SEL_IN[0]) dev <= WB_DAT_IN[7:0];
          default: ;
        endcase
      end
      // Software write-one sets; hardware sets win over dispatch clear
      flags1 <= (flags1 & ~clr1) | FLAG1_SET_IN |              // [RULE1]
                ((wb_wr && WB_ADR_IN == `IDS_A_FLAGS1) ?
                 WB_DAT_IN[15:0] : 16'h0000);                 // [RULE23]
      flags2 <= (flags2 & ~clr2) | FLAG2_SET_IN |
                ((wb_wr && WB_ADR_IN == `IDS_A_FLAGS2) ?
                 WB_DAT_IN[15:0] : 16'h0000);
      case (state)
        ST_IDLE: begin
          seg <= kseg;
          need_parm <= kparm;
          idx <= 2'h0;
          pw  <= (kind == K_POWER);
          interrupt_control_stack <= (kind == K_ICS) || (kind == K_EXT);
          ext <= (kind == K_EXT);
          case (kind)
            K_POWER: begin
              if (!ctrl[`IDS_C_AUTO])
                ctrl[`IDS_C_HALT] <= 1'b1;                   // [RULE4]
              else
                state <= ST_RDQI;
            end
            K_ICS, K_EXT, K_PUSH: state <= ST_MARK;  // [RULE6] [RULE11]
            K_OVF: stat[`IDS_ST_OVF] <= 1'b1;               // [RULE10]
            K_STOP: begin
              ctrl[`IDS_C_RUN]  <= 1'b0;         // [RULE12] [RULE13]
              ctrl[`IDS_C_HALT] <= 1'b1;
            end
            K_PANEL: ctrl[`IDS_C_HALT] <= 1'b1;
            default: ;
          endcase
        end
        ST_MARK: begin
          if (!MEM_REQ_OUT) begin
            case (idx)
              2'h0: t_mem(1'b1, s + 16'h0001, x);
              2'h1: t_mem(1'b1, s + 16'h0001, p - pb);
              2'h2: t_mem(1'b1, s + 16'h0001, stat);
              default: t_mem(1'b1, s + 16'h0001, s + 16'h0001 - q);
            endcase
          end else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            s   <= s + 16'h0001;
            idx <= idx + 2'h1;
            if (idx == `IDS_MARK_LAST) begin
              q <= s + 16'h0001;
              state <= interrupt_control_stack ? ST_PUSHDB : ST_PARM;
            end
          end
        end
        ST_PUSHDB: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b1, s + 16'h0001, db);                  // [RULE6]
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            s <= s + 16'h0001;
            if (!ctrl[`IDS_C_ONICS] || ctrl[`IDS_C_DISP])
              state <= ST_RDQI;
            else
              state <= ST_PARM;                             // [RULE8]
          end
        end
        ST_RDQI: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, `IDS_M_QI, 16'h0000);
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            qi <= MEM_RDATA_IN;
            state <= ST_RDZI;
          end
        end
        ST_RDZI: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, `IDS_M_ZI, 16'h0000);
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            zi <= MEM_RDATA_IN;
            if (pw)
              state <= ST_RDS;
            else if (!ctrl[`IDS_C_ONICS])
              state <= ST_SAVES;
            else begin
              q <= qi;                                      // [RULE8]
              z <= MEM_RDATA_IN;
              s <= qi + 16'h0001;
              state <= ST_PARM;
            end
          end
        end
        ST_RDS: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, qi - `IDS_QI_SAVE, 16'h0000);
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            q  <= qi;                                       // [RULE5]
            z  <= zi;
            s  <= MEM_RDATA_IN;
            db <= 16'h0000;
            dl <= 16'h0000;
            ctrl[`IDS_C_ONICS] <= 1'b1;
            state <= ST_PARM;
          end
        end
        ST_SAVES: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b1, qi - `IDS_QI_SAVE, s);              // [RULE7]
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            q <= qi;
            z <= zi;
            s <= qi + 16'h0001;
            ctrl[`IDS_C_ONICS] <= 1'b1;
            state <= ST_PARM;
          end
        end
        ST_PARM: begin
          if (!need_parm) begin                             // [RULE14]
            stat[`IDS_ST_EXTEN] <= 1'b0;                    // [RULE15]
            state <= ext ? ST_DRT0 : ST_RDTP;
          end else if (!MEM_REQ_OUT)
            t_mem(1'b1, s + 16'h0001, parm);
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            s <= s + 16'h0001;
            need_parm <= 1'b0;
          end
        end
        ST_DRT0: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, drt_adr + `IDS_DRT_PI, 16'h0000);
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            p  <= MEM_RDATA_IN;                             // [RULE16]
            pb <= 16'h0000;
            pl <= 16'hFFFF;
            state <= ST_DRT1;
          end
        end
        ST_DRT1: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, drt_adr + `IDS_DRT_DBI, 16'h0000);
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            db <= MEM_RDATA_IN;                             // [RULE16]
            stat[`IDS_ST_MODE]  <= 1'b1;                    // [RULE17]
            stat[`IDS_ST_EXTEN] <= 1'b1;
            state <= ST_FETCH;
          end
        end
        ST_RDTP: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, `IDS_M_CSTPTR, 16'h0000);           // [RULE21]
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            tp <= MEM_RDATA_IN;
            state <= ST_ENT0;
          end
        end
        ST_ENT0: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, ent_adr, 16'h0000);                 // [RULE21]
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            ent0 <= MEM_RDATA_IN;
            state <= ST_ENT1;
          end
        end
        ST_ENT1: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, ent_adr + 16'h0001, 16'h0000);
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            pb <= MEM_RDATA_IN;                             // [RULE18]
            p  <= MEM_RDATA_IN;
            pl <= MEM_RDATA_IN + (ent0 & `IDS_CST_LEN);
            stat[`IDS_ST_MODE] <= ent0[`IDS_CST_MODE];      // [RULE22]
            stat[15:8] <= seg;                              // [RULE19]
            stat[`IDS_ST_TRAPEN] <= 1'b0;
            state <= ent0[`IDS_CST_REF] ? ST_FETCH : ST_WREF;
          end
        end
        ST_WREF: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b1, ent_adr, ent0 | 16'h8000);          // [RULE18]
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (!MEM_REQ_OUT)
            t_mem(1'b0, p, 16'h0000);                       // [RULE20]
          else if (ack_now) begin
            MEM_REQ_OUT <= 1'b0;
            instr <= MEM_RDATA_IN;
            EXEC_START_OUT <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/ids_defines.vh
// Constants of the interrupt dispatch sequencer
`ifndef IDS_DEFINES_VH
`define IDS_DEFINES_VH
// Wishbone register byte addresses
`define IDS_A_FLAGS1 8'h00
`define IDS_A_FLAGS2 8'h04
`define IDS_A_CTRL   8'h08
`define IDS_A_STAT   8'h0C
`define IDS_A_Q      8'h10
`define IDS_A_Z      8'h14
`define IDS_A_S      8'h18
`define IDS_A_DB     8'h1C
`define IDS_A_DL     8'h20
`define IDS_A_PB     8'h24
`define IDS_A_PL     8'h28
`define IDS_A_P      8'h2C
`define IDS_A_X      8'h30
`define IDS_A_PARM   8'h34
`define IDS_A_DEV    8'h38
`define IDS_A_STATE  8'h3C
`define IDS_A_INSTR  8'h40
// run_interrupt_flags_one bits
`define IDS_F1_POWER 0
`define IDS_F1_ICSI  1
`define IDS_F1_EXT   2
`define IDS_F1_MISC  3
`define IDS_F1_MOD   4
`define IDS_F1_PAR   5
`define IDS_F1_PANEL 6
// run_interrupt_flags_two bits
`define IDS_F2_ARITH 0
`define IDS_F2_SYS   1
// Control register bits
`define IDS_C_AUTO   0
`define IDS_C_RUN    1
`define IDS_C_ONICS  2
`define IDS_C_DISP   3
`define IDS_C_HALT   4
// Status register bits
`define IDS_ST_MODE  0
`define IDS_ST_EXTEN 1
`define IDS_ST_TRAPEN 2
`define IDS_ST_OVF   3
// Memory locations and table layout
`define IDS_M_CSTPTR 16'h0000
`define IDS_M_QI     16'h0005
`define IDS_M_ZI     16'h0006
`define IDS_QI_SAVE  16'h0005
`define IDS_CST_MODE 1
`define IDS_CST_REF  15
`define IDS_CST_LEN  16'h7FFC
`define IDS_DRT_PI   16'h0000
`define IDS_DRT_DBI  16'h0001
// Interrupt code segment numbers
`define IDS_SEG_POWER 8'h01
`define IDS_SEG_ICSI  8'h02
`define IDS_SEG_MISC  8'h03
`define IDS_SEG_MOD   8'h04
`define IDS_SEG_PAR   8'h05
`define IDS_SEG_TRAP  8'h0F
// Reset values and last marker word index
`define IDS_R_STAT   16'h0001
`define IDS_R_CTRL   5'h02
`define IDS_MARK_LAST 2'h3
`endif

// >>> verif/ids_monitor.sv
// Port checker for the interrupt dispatch sequencer
`timescale 1ns/1ps
`default_nettype none
module ids_monitor (
  input wire logic        CLK_IN,         // Clock
  input wire logic        RESETN_IN,      // Reset, active low
  input wire logic        WB_CYC_IN,      // Bus cycle
  input wire logic        WB_STB_IN,      // Bus strobe
  input wire logic        WB_ACK_OUT,     // Bus acknowledge
  input wire logic        MEM_REQ_OUT,    // Memory request
  input wire logic        MEM_WE_OUT,     // Memory write
  input wire logic [15:0] MEM_ADDR_OUT,   // Memory address
  input wire logic [15:0] MEM_WDATA_OUT,  // Memory write data
  input wire logic        MEM_ACK_IN,     // Memory acknowledge
  input wire logic        HALT_LAMP_OUT,  // Halt indicator
  input wire logic        BUSY_OUT,       // Dispatch busy
  input wire logic        EXEC_START_OUT  // Routine start
);
  // ********************************************************
  // Properties
  // ********************************************************
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  property p_wb_ack;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("request not acknowledged");
  property p_wb_quiet;
    !(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT;
  endproperty
  a_wb_quiet: assert property (p_wb_quiet)
    else $error("acknowledge without request");
  property p_req_hold;
    MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT)
      && $stable(MEM_WE_OUT) && $stable(MEM_WDATA_OUT);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed before acknowledge");
  property p_req_drop;
    MEM_REQ_OUT && MEM_ACK_IN |=> !MEM_REQ_OUT;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("memory request held after acknowledge");
  property p_req_busy;
    $rose(MEM_REQ_OUT) |-> ##[0:1] BUSY_OUT;
  endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("memory access outside dispatch");
  property p_exec_one;
    EXEC_START_OUT |=> !EXEC_START_OUT;
  endproperty
  a_exec_one: assert property (p_exec_one)
    else $error("routine start longer than one cycle");
  property p_exec_clean;
    EXEC_START_OUT |-> !MEM_REQ_OUT && !HALT_LAMP_OUT;
  endproperty
  a_exec_clean: assert property (p_exec_clean)
    else $error("routine start while busy on memory or halted");
  property p_halt_nomem;
    HALT_LAMP_OUT && !MEM_REQ_OUT |=> !MEM_REQ_OUT;
  endproperty
  a_halt_nomem: assert property (p_halt_nomem)
    else $error("memory access while halted");
  c_exec: cover property (EXEC_START_OUT);
  c_halt: cover property ($rose(HALT_LAMP_OUT));
  c_write: cover property (MEM_REQ_OUT && MEM_WE_OUT && MEM_ACK_IN);
endmodule
bind ids_sequencer ids_monitor u_mon (.CLK_IN, .RESETN_IN, .WB_CYC_IN,
  .WB_STB_IN, .WB_ACK_OUT, .MEM_REQ_OUT, .MEM_WE_OUT, .MEM_ADDR_OUT,
  .MEM_WDATA_OUT, .MEM_ACK_IN, .HALT_LAMP_OUT, .BUSY_OUT,
  .EXEC_START_OUT);
`default_nettype wire

// >>> verif/ids_mem_model.sv
// Main memory model holding stacks and segment tables
`timescale 1ns/1ps
`default_nettype none
module ids_mem_model (
  input  wire logic        clk_in,    // Clock
  input  wire logic        rstn_in,   // Reset, active low
  input  wire logic        req_in,    // Request
  input  wire logic        we_in,     // Write
  input  wire logic [15:0] addr_in,   // Word address
  input  wire logic [15:0] wdata_in,  // Write data
  output var  logic [15:0] rdata_out, // Read data
  output var  logic        ack_out    // Acknowledge pulse
);
  logic [15:0] word [0:255];
  logic [1:0]  wait_n;
  initial begin
    for (int i = 0; i < 256; i++) word[i] = 16'hA500 | 16'(i);
    word[0] = 16'h0040; // Table pointer at word 0
    word[5] = 16'h0080;
    word[6] = 16'h00C0;
    for (int i = 0; i < 16; i++) begin
      word[64 + 2 * i] = 16'h0010 | 16'((i % 2) * 2); // Mode in bit 1
      word[65 + 2 * i] = 16'h00D0 + 16'(i);
    end
    word[8'hC0] = 16'h00F0;
    word[8'hC1] = 16'h1234;
  end
  // Random wait states; data line toggles when not answering
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out <= 1'b0;
      wait_n <= 2'h0;
      rdata_out <= 16'h5A5A;
    end else if (req_in && !ack_out && wait_n == 2'h0) begin
      ack_out <= 1'b1;
      wait_n <= 2'($urandom % 3);
      if (we_in) word[addr_in[7:0]] <= wdata_in;
      else rdata_out <= word[addr_in[7:0]];
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && wait_n != 2'h0) wait_n <= wait_n - 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/ids_tb.sv
// Self-checking testbench of the dispatch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ids_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("mismatch t=%0t got %h exp %h", $time, g, e); \
  end end
module testbench;
  logic        CLK_IN = 0, RESETN_IN = 0, WB_CYC_IN = 0, WB_STB_IN = 0;
  logic        WB_WE_IN = 0, WB_ACK_OUT, MEM_REQ_OUT, MEM_WE_OUT;
  logic        MEM_ACK_IN, HALT_LAMP_OUT, BUSY_OUT, EXEC_START_OUT;
  logic [7:0]  WB_ADR_IN = 0;
  logic [3:0]  WB_SEL_IN = 4'h3;
  logic [31:0] WB_DAT_IN = 0, WB_DAT_OUT;
  logic [15:0] FLAG1_SET_IN = 0, FLAG2_SET_IN = 0, MEM_RDATA_IN;
  logic [15:0] MEM_ADDR_OUT, MEM_WDATA_OUT, s0, db0, exp_w, exp_q[$];
  int          failures = 0, samples_checked = 0, n_exec = 0, k = 0;
  // ********************************************************
  // Harness
  // ********************************************************
  always #4 CLK_IN = ~CLK_IN;
  ids_sequencer dut (.CLK_IN, .RESETN_IN, .WB_CYC_IN, .WB_STB_IN,
    .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT,
    .WB_ACK_OUT, .FLAG1_SET_IN, .FLAG2_SET_IN, .MEM_REQ_OUT, .MEM_WE_OUT,
    .MEM_ADDR_OUT, .MEM_WDATA_OUT, .MEM_RDATA_IN, .MEM_ACK_IN,
    .HALT_LAMP_OUT, .BUSY_OUT, .EXEC_START_OUT);
  ids_mem_model u_mem (.clk_in(CLK_IN), .rstn_in(RESETN_IN),
    .req_in(MEM_REQ_OUT), .we_in(MEM_WE_OUT), .addr_in(MEM_ADDR_OUT),
    .wdata_in(MEM_WDATA_OUT), .rdata_out(MEM_RDATA_IN),
    .ack_out(MEM_ACK_IN));
  always @(posedge CLK_IN) begin
    if (EXEC_START_OUT === 1'b1) n_exec++;
    if (WB_ACK_OUT === 1'b1 && WB_WE_IN === 1'b0) begin
      exp_w = exp_q.pop_front();
      `CHK(WB_DAT_OUT, {16'h0, exp_w})
    end
  end
  task wb(input [7:0] a, input w, input [15:0] d);
    @(posedge CLK_IN);
    WB_CYC_IN <= 1;
    WB_STB_IN <= 1;
    WB_WE_IN <= w;
    WB_ADR_IN <= a;
    WB_DAT_IN <= {16'h0, d};
    do @(posedge CLK_IN); while (WB_ACK_OUT !== 1'b1);
    WB_CYC_IN <= 0;
    WB_STB_IN <= 0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    exp_q.push_back(e);
    wb(a, 0, 16'h0);
  endtask
  task fire(input [15:0] a, input [15:0] b);
    @(posedge CLK_IN);
    FLAG1_SET_IN <= a;
    FLAG2_SET_IN <= b;
    @(posedge CLK_IN);
    FLAG1_SET_IN <= 0;
    FLAG2_SET_IN <= 0;
    repeat (4) @(posedge CLK_IN);
    while (BUSY_OUT !== 1'b0) @(posedge CLK_IN);
  endtask
  task fin;
    k++;
    $display("test %0d done", k);
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h80C64D8E));
    repeat (8) @(posedge CLK_IN);
    RESETN_IN <= 1;
    rd(`IDS_A_CTRL, 16'h0002);
    rd(`IDS_A_STAT, 16'h0001);
    rd(8'h7C, 16'h0000);
    fin();
    s0 = 16'h10 + 16'($urandom % 32);
    db0 = 16'($urandom);
    wb(`IDS_A_S, 1, s0);
    wb(`IDS_A_DB, 1, db0);
    wb(`IDS_A_PARM, 1, 16'h0077);
    fire(16'h0002, 16'h0);
    rd(`IDS_A_Q, 16'h0080);
    rd(`IDS_A_Z, 16'h00C0);
    rd(`IDS_A_S, 16'h0082);
    rd(`IDS_A_PB, 16'h00D2);
    rd(`IDS_A_P, 16'h00D2);
    rd(`IDS_A_PL, 16'h00E2);
    rd(`IDS_A_STAT, 16'h0200);
    rd(`IDS_A_CTRL, 16'h0006);
    rd(`IDS_A_FLAGS1, 16'h0000);
    rd(`IDS_A_INSTR, 16'hA5D2);
    `CHK(u_mem.word[8'h7B], s0 + 16'h5)
    `CHK(u_mem.word[s0 + 5], db0)
    `CHK(u_mem.word[s0 + 3], 16'h0001)
    `CHK(u_mem.word[8'h82], 16'h0077)
    `CHK(u_mem.word[8'h44], 16'h8010)
    fin();
    fire(16'h0, 16'h0001);
    rd(`IDS_A_STAT, 16'h0208);
    `CHK(n_exec, 1)
    fin();
    wb(`IDS_A_STAT, 1, 16'h0202);
    wb(`IDS_A_DEV, 1, 16'h0030);
    fire(16'h0004, 16'h0);
    rd(`IDS_A_PB, 16'h0000);
    rd(`IDS_A_PL, 16'hFFFF);
    rd(`IDS_A_P, 16'h00F0);
    rd(`IDS_A_DB, 16'h1234);
    rd(`IDS_A_STAT, 16'h0203);
    rd(`IDS_A_INSTR, 16'hA5F0);
    fin();
    wb(`IDS_A_STAT, 1, 16'h0400);
    fire(16'h0010, 16'h0);
    rd(`IDS_A_CTRL, 16'h0014);
    `CHK(HALT_LAMP_OUT, 1'b1)
    `CHK(n_exec, 2)
    fin();
    wb(`IDS_A_CTRL, 1, 16'h0007);
    fire(16'h0001, 16'h0);
    rd(`IDS_A_S, s0 + 16'h5);
    rd(`IDS_A_Q, 16'h0080);
    rd(`IDS_A_Z, 16'h00C0);
    rd(`IDS_A_DB, 16'h0000);
    rd(`IDS_A_DL, 16'h0000);
    rd(`IDS_A_STAT, 16'h0101);
    fin();
    wb(`IDS_A_CTRL, 1, 16'h0006);
    fire(16'h0001, 16'h0);
    rd(`IDS_A_CTRL, 16'h0016);
    `CHK(n_exec, 3)
    fin();
    wb(`IDS_A_CTRL, 1, 16'h0002);
    wb(`IDS_A_STAT, 1, 16'h0500);
    fire(16'h0020, 16'h0);
    rd(`IDS_A_CTRL, 16'h0010);
    fin();
    wrap_up();
  end
endmodule
`default_nettype wire
